/* File: src/scr_cdr_regs.sv */
`timescale 1ns/1ps
`include "scr_regs.svh"


module scr_cdr_regs #(
  parameter int unsigned QDIV_80 = `SCR_QDIV_80,
  parameter int unsigned QDIV_40 = `SCR_QDIV_40,
  parameter int unsigned QDIV_20 = `SCR_QDIV_20,
  parameter int unsigned QDIV_10 = `SCR_QDIV_10,
  parameter int unsigned QCNT_W = 12
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spiCsN,
  input wire logic spiClk,
  input wire logic spiDi,
  output logic spiDo,
  output logic spiDoEn,
  input wire logic softResetReq,
  input wire logic restartReq,
  input wire logic canRx,
  input wire scr_pkg::scr_byte_t bitTimeNominal,
  output logic recoveryEnable,
  output scr_pkg::scr_byte_t recoveredBitTime,
  output logic recoveredValid,
  output logic [1:0] activeTimeConst
);

  if (QDIV_80 < 1 || QDIV_40 < QDIV_80 || QDIV_20 < QDIV_40 || QDIV_10 < QDIV_20 ||
      QDIV_10 > 255) begin : g_divCheck
    $error("quantum dividers must be ascending and within 1 to 255");
  end
  if (QCNT_W < 9 || QCNT_W > 16) begin : g_cntCheck
    $error("quantum counter width must be 9 to 16");
  end

  logic enable_q;
  logic [1:0] filtSel_q;
  logic [1:0] clkSel_q;
  scr_pkg::scr_byte_t upper_q;
  scr_pkg::scr_byte_t lower_q;
  logic upHit_q;
  logic loHit_q;
  logic [1:0] tcCode_q;

  logic hdrValid;
  logic [6:0] hdrAddr;
  logic hdrMode;
  logic frameValid;
  logic [6:0] frameAddr;
  logic frameMode;
  scr_pkg::scr_byte_t frameData;
  scr_pkg::scr_byte_t rdData;

  logic wrCtrl1;
  logic wrClk;
  logic wrUpper;
  logic wrLower;
  logic clrStatus;

  logic [7:0] divCnt_q;
  logic [7:0] divMax;
  logic qTick;
  logic rxPrev_q;
  logic fallEdge;
  logic [QCNT_W-1:0] qCnt_q;
  logic seenEdge_q;
  logic [3:0] bitsApart;
  scr_pkg::scr_byte_t sample;
  logic [2:0] shiftSel;
  logic [1:0] tcCode;
  logic sampleOk;
  logic [15:0] acc_q;
  logic [16:0] diff;
  logic [16:0] step;
  logic [15:0] accNext;
  scr_pkg::scr_byte_t estimate;
  logic estReady_q;
  logic clampUp;
  logic clampLo;

  // read mux with zero for unmapped addresses
  function automatic scr_pkg::scr_byte_t readMux(input logic [6:0] addr,
                                                 input logic en,
                                                 input logic [1:0] filt,
                                                 input logic [1:0] clk,
                                                 input scr_pkg::scr_byte_t up,
                                                 input scr_pkg::scr_byte_t lo,
                                                 input logic [4:0] stat);
    scr_pkg::scr_byte_t v;
    v = 8'h00;
    case (addr)
      `SCR_OFS_CTRL1: begin
        v[`SCR_CTRL1_EN_BIT] = en;
        v[`SCR_CTRL1_FILT_LSB +: 2] = filt;
      end
      `SCR_OFS_CLKCTRL: begin
        v[1:0] = clk;
      end
      `SCR_OFS_UPPER: begin
        v = up;
      end
      `SCR_OFS_LOWER: begin
        v = lo;
      end
      `SCR_OFS_STATUS: begin
        v[4:0] = stat;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  function automatic logic [7:0] quantumDiv(input logic [1:0] sel);
    logic [7:0] d;
    d = 8'h01;
    case (scr_pkg::scr_clk_e'(sel))
      scr_pkg::SCR_CLK80: begin
        d = 8'(QDIV_80);
      end
      scr_pkg::SCR_CLK40: begin
        d = 8'(QDIV_40);
      end
      scr_pkg::SCR_CLK20: begin
        d = 8'(QDIV_20);
      end
      scr_pkg::SCR_CLK10: begin
        d = 8'(QDIV_10);
      end
      default: begin
        d = 8'h01;
      end
    endcase
    return d;
  endfunction

  // rounded count of nominal bits in a quantum count
  function automatic logic [3:0] roundBits(input logic [QCNT_W-1:0] cnt,
                                           input scr_pkg::scr_byte_t nom);
    logic [QCNT_W:0] q;
    q = '0;
    if (nom != 8'h00) begin
      q = ({1'b0, cnt} + {{(QCNT_W-7){1'b0}}, nom[7:1]}) / {{(QCNT_W-7){1'b0}}, nom};
    end
    if (q > (QCNT_W+1)'(15)) begin
      q = (QCNT_W+1)'(15);
    end
    return q[3:0];
  endfunction

  assign wrCtrl1 = frameValid & frameMode & (frameAddr == `SCR_OFS_CTRL1);
  assign wrClk = frameValid & frameMode & (frameAddr == `SCR_OFS_CLKCTRL);
  assign wrUpper = frameValid & frameMode & (frameAddr == `SCR_OFS_UPPER);
  assign wrLower = frameValid & frameMode & (frameAddr == `SCR_OFS_LOWER);
  // clear access on the status byte
  assign clrStatus = frameValid & frameMode & (frameAddr == `SCR_OFS_STATUS);

  assign rdData = readMux(hdrAddr, enable_q, filtSel_q, clkSel_q, upper_q, lower_q,
                          {tcCode_q, enable_q, loHit_q, upHit_q});

  scr_spi_frame u_frame (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .spiCsN(spiCsN),
    .spiClk(spiClk),
    .spiDi(spiDi),
    .spiDo(spiDo),
    .spiDoEn(spiDoEn),
    .rdData(rdData),
    .hdrValid(hdrValid),
    .hdrAddr(hdrAddr),
    .hdrMode(hdrMode),
    .frameValid(frameValid),
    .frameAddr(frameAddr),
    .frameMode(frameMode),
    .frameData(frameData)
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= 1'((`SCR_RST_CTRL1 >> `SCR_CTRL1_EN_BIT) & 8'h01);
      filtSel_q <= 2'((`SCR_RST_CTRL1 >> `SCR_CTRL1_FILT_LSB) & 8'h03);
    end else if (softResetReq) begin
      enable_q <= 1'((`SCR_RST_CTRL1 >> `SCR_CTRL1_EN_BIT) & 8'h01);
      filtSel_q <= 2'((`SCR_RST_CTRL1 >> `SCR_CTRL1_FILT_LSB) & 8'h03);
    end else if (restartReq) begin
      enable_q <= 1'b0;
    end else if (wrCtrl1) begin
      enable_q <= frameData[`SCR_CTRL1_EN_BIT];
      filtSel_q <= frameData[`SCR_CTRL1_FILT_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clkSel_q <= 2'(`SCR_RST_CLKCTRL & `SCR_CLKCTRL_MASK);
    end else if (softResetReq) begin
      clkSel_q <= 2'(`SCR_RST_CLKCTRL & `SCR_CLKCTRL_MASK);
    end else if (wrClk) begin
      clkSel_q <= frameData[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      upper_q <= `SCR_RST_UPPER;
      lower_q <= `SCR_RST_LOWER;
    end else if (softResetReq) begin
      upper_q <= `SCR_RST_UPPER;
      lower_q <= `SCR_RST_LOWER;
    end else begin
      if (wrUpper) begin
        upper_q <= frameData;
      end
      if (wrLower) begin
        lower_q <= frameData;
      end
    end
  end

  assign divMax = quantumDiv(clkSel_q);
  assign qTick = enable_q && (divCnt_q >= divMax - 8'h01);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_q <= 8'h00;
    end else if (!enable_q || qTick) begin
      divCnt_q <= 8'h00;
    end else begin
      divCnt_q <= divCnt_q + 8'h01;
    end
  end

  assign fallEdge = rxPrev_q & ~canRx;

  // edge spacing counted only while enabled
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxPrev_q <= 1'b1;
      qCnt_q <= '0;
      seenEdge_q <= 1'b0;
    end else begin
      rxPrev_q <= canRx;
      if (!enable_q) begin
        qCnt_q <= '0;
        seenEdge_q <= 1'b0;
      end else if (fallEdge) begin
        // tick of the edge cycle counts, so spacing is not one short
        qCnt_q <= {{(QCNT_W-1){1'b0}}, qTick};
        seenEdge_q <= 1'b1;
      end else if (qTick && qCnt_q != '1) begin
        qCnt_q <= qCnt_q + 1'b1;
      end
    end
  end

  assign bitsApart = roundBits(qCnt_q, bitTimeNominal);
  assign sampleOk = enable_q && fallEdge && seenEdge_q && qCnt_q != '1 &&
                    bitsApart != 4'd0 && bitsApart <= `SCR_ADAPT_MAX;

  always_comb begin
    logic [QCNT_W-1:0] per;
    per = '0;
    if (bitsApart != 4'd0) begin
      per = qCnt_q / {{(QCNT_W-4){1'b0}}, bitsApart};
    end
    sample = (per > QCNT_W'(255)) ? 8'hFF : per[7:0];
  end

  // adaptive time constant from edge spacing
  always_comb begin
    tcCode = filtSel_q;
    if (scr_pkg::scr_filt_e'(filtSel_q) == scr_pkg::SCR_TCADAPT) begin
      if (bitsApart >= `SCR_ADAPT_SHORT_MIN) begin
        tcCode = scr_pkg::SCR_TC8;
      end else if (bitsApart >= `SCR_ADAPT_MID_MIN) begin
        tcCode = scr_pkg::SCR_TC16;
      end else begin
        tcCode = scr_pkg::SCR_TC32;
      end
    end
    case (scr_pkg::scr_filt_e'(tcCode))
      scr_pkg::SCR_TC8: begin
        shiftSel = `SCR_SHIFT_TC8;
      end
      scr_pkg::SCR_TC16: begin
        shiftSel = `SCR_SHIFT_TC16;
      end
      default: begin
        shiftSel = `SCR_SHIFT_TC32;
      end
    endcase
  end

  assign diff = {1'b0, sample, 8'h00} - {1'b0, acc_q};
  assign step = 17'($signed(diff) >>> shiftSel);
  assign accNext = 16'({1'b0, acc_q} + step);
  assign estimate = accNext[15:8];
  assign clampUp = estimate > upper_q;
  assign clampLo = estimate < lower_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= 16'h0000;
      tcCode_q <= 2'b00;
    end else if (!enable_q) begin
      acc_q <= {bitTimeNominal, 8'h00};
    end else if (sampleOk) begin
      if (clampUp) begin
        acc_q <= {upper_q, 8'h00};
      end else if (clampLo) begin
        acc_q <= {lower_q, 8'h00};
      end else begin
        acc_q <= accNext;
      end
      tcCode_q <= tcCode;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      recoveredBitTime <= 8'h00;
      recoveredValid <= 1'b0;
      estReady_q <= 1'b0;
    end else begin
      recoveredValid <= 1'b0;
      if (!enable_q) begin
        estReady_q <= 1'b0;
      end else if (sampleOk) begin
        estReady_q <= 1'b1;
        recoveredValid <= 1'b1;
        recoveredBitTime <= clampUp ? upper_q : (clampLo ? lower_q : estimate);
      end
    end
  end

  // flags held until cleared, set wins over clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      upHit_q <= 1'b0;
      loHit_q <= 1'b0;
    end else if (softResetReq) begin
      upHit_q <= 1'b0;
      loHit_q <= 1'b0;
    end else begin
      if (sampleOk && clampUp) begin
        upHit_q <= 1'b1;
      end else if (clrStatus) begin
        upHit_q <= 1'b0;
      end
      if (sampleOk && clampLo) begin
        loHit_q <= 1'b1;
      end else if (clrStatus) begin
        loHit_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      recoveryEnable <= 1'b0;
      activeTimeConst <= 2'b00;
    end else begin
      recoveryEnable <= enable_q;
      activeTimeConst <= tcCode_q;
    end
  end

endmodule

/* File: src/scr_regs.svh */
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

// register offsets on the 7-bit frame address
`define SCR_OFS_CTRL1 7'h3C
`define SCR_OFS_CLKCTRL 7'h3D
`define SCR_OFS_UPPER 7'h3E
`define SCR_OFS_LOWER 7'h3F
`define SCR_OFS_STATUS 7'h4F

// reset values
`define SCR_RST_CTRL1 8'h04
`define SCR_RST_CLKCTRL 8'h00
`define SCR_RST_UPPER 8'hA8
`define SCR_RST_LOWER 8'h98

// field positions and implemented-bit masks
`define SCR_CTRL1_EN_BIT 0
`define SCR_CTRL1_FILT_LSB 2
`define SCR_CTRL1_MASK 8'h0D
`define SCR_CLKCTRL_MASK 8'h03
`define SCR_STAT_UPHIT_BIT 0
`define SCR_STAT_LOHIT_BIT 1
`define SCR_STAT_ACTIVE_BIT 2
`define SCR_STAT_TC_LSB 3

// frame layout
`define SCR_FRAME_BITS 5'd16
`define SCR_HDR_BITS 5'd8

// filter shifts for time constants 8, 16, 32
`define SCR_SHIFT_TC8 3'd3
`define SCR_SHIFT_TC16 3'd4
`define SCR_SHIFT_TC32 3'd5

// adaptive thresholds in bits between falling edges
`define SCR_ADAPT_LONG_MIN 4'd2
`define SCR_ADAPT_MID_MIN 4'd4
`define SCR_ADAPT_SHORT_MIN 4'd9
`define SCR_ADAPT_MAX 4'd10

// quantum dividers approximating 80/40/20/10 MHz from sys_clk
`define SCR_QDIV_80 1
`define SCR_QDIV_40 2
`define SCR_QDIV_20 4
`define SCR_QDIV_10 8

`endif

/* File: src/scr_pkg.sv */
package scr_pkg;

  typedef logic [7:0] scr_byte_t;

  typedef enum logic [1:0] {
    SCR_TC8 = 2'b00,
    SCR_TC16 = 2'b01,
    SCR_TC32 = 2'b10,
    SCR_TCADAPT = 2'b11
  } scr_filt_e;

  typedef enum logic [1:0] {
    SCR_CLK80 = 2'b00,
    SCR_CLK40 = 2'b01,
    SCR_CLK20 = 2'b10,
    SCR_CLK10 = 2'b11
  } scr_clk_e;

  typedef enum logic [1:0] {
    SCR_SPI_IDLE = 2'b00,
    SCR_SPI_HDR = 2'b01,
    SCR_SPI_DATA = 2'b11,
    SCR_SPI_ERR = 2'b10
  } scr_spi_e;

endpackage

/* File: src/scr_spi_frame.sv */
`timescale 1ns/1ps
`include "scr_regs.svh"

module scr_spi_frame (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spiCsN,
  input wire logic spiClk,
  input wire logic spiDi,
  output logic spiDo,
  output logic spiDoEn,
  input wire scr_pkg::scr_byte_t rdData,
  output logic hdrValid,
  output logic [6:0] hdrAddr,
  output logic hdrMode,
  output logic frameValid,
  output logic [6:0] frameAddr,
  output logic frameMode,
  output scr_pkg::scr_byte_t frameData
);

  scr_pkg::scr_spi_e state_q;
  logic clkPrev_q;
  logic csPrev_q;
  logic [4:0] bitCnt_q;
  logic [15:0] inShift_q;
  logic [7:0] outShift_q;
  logic loadPend_q;
  logic rise;
  logic fall;
  logic csRise;
  logic [7:0] hdrByte;

  assign rise = spiClk & ~clkPrev_q;
  assign fall = ~spiClk & clkPrev_q;
  assign csRise = spiCsN & ~csPrev_q;
  assign hdrByte = {spiDi, inShift_q[15:9]};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clkPrev_q <= 1'b0;
      csPrev_q <= 1'b1;
    end else begin
      clkPrev_q <= spiClk;
      csPrev_q <= spiCsN;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= scr_pkg::SCR_SPI_IDLE;
      bitCnt_q <= 5'd0;
      inShift_q <= 16'h0000;
    end else if (spiCsN) begin
      state_q <= scr_pkg::SCR_SPI_IDLE;
      bitCnt_q <= 5'd0;
    end else begin
      case (state_q)
        scr_pkg::SCR_SPI_IDLE: begin
          state_q <= scr_pkg::SCR_SPI_HDR;
          bitCnt_q <= 5'd0;
        end
        scr_pkg::SCR_SPI_HDR: begin
          if (rise) begin
            inShift_q <= {spiDi, inShift_q[15:1]};
            bitCnt_q <= bitCnt_q + 5'd1;
            if (bitCnt_q == `SCR_HDR_BITS - 5'd1) begin
              state_q <= scr_pkg::SCR_SPI_DATA;
            end
          end
        end
        scr_pkg::SCR_SPI_DATA: begin
          if (rise) begin
            inShift_q <= {spiDi, inShift_q[15:1]};
            if (bitCnt_q == `SCR_FRAME_BITS) begin
              state_q <= scr_pkg::SCR_SPI_ERR;
            end else begin
              bitCnt_q <= bitCnt_q + 5'd1;
            end
          end
        end
        default: begin
          state_q <= scr_pkg::SCR_SPI_ERR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hdrValid <= 1'b0;
      hdrAddr <= 7'h00;
      hdrMode <= 1'b0;
    end else begin
      hdrValid <= 1'b0;
      if (!spiCsN && state_q == scr_pkg::SCR_SPI_HDR && rise &&
          bitCnt_q == `SCR_HDR_BITS - 5'd1) begin
        hdrValid <= 1'b1;
        hdrAddr <= hdrByte[6:0];
        hdrMode <= hdrByte[7];
      end
    end
  end

  // data byte on frame bits 8 to 15
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frameValid <= 1'b0;
      frameAddr <= 7'h00;
      frameMode <= 1'b0;
      frameData <= 8'h00;
    end else begin
      frameValid <= 1'b0;
      if (csRise && state_q == scr_pkg::SCR_SPI_DATA && bitCnt_q == `SCR_FRAME_BITS) begin
        frameValid <= 1'b1;
        frameAddr <= hdrAddr;
        frameMode <= hdrMode;
        frameData <= inShift_q[15:8];
      end
    end
  end

  // read byte shifted out lsb first
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      loadPend_q <= 1'b0;
      outShift_q <= 8'h00;
      spiDo <= 1'b0;
      spiDoEn <= 1'b0;
    end else begin
      spiDoEn <= ~spiCsN;
      loadPend_q <= hdrValid;
      if (spiCsN) begin
        spiDo <= 1'b0;
        outShift_q <= 8'h00;
      end else if (loadPend_q) begin
        outShift_q <= rdData;
      end else if (fall && state_q == scr_pkg::SCR_SPI_DATA) begin
        spiDo <= outShift_q[0];
        outShift_q <= {1'b0, outShift_q[7:1]};
      end
    end
  end

endmodule

/* File: testbench/scr_cdr_regs_monitor.sv */
`timescale 1ns/1ps
module scr_cdr_regs_monitor #(
  parameter int unsigned QCNT_W = 12
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spiCsN,
  input wire logic spiClk,
  input wire logic spiDi,
  input wire logic spiDo,
  input wire logic spiDoEn,
  input wire logic softResetReq,
  input wire logic restartReq,
  input wire logic canRx,
  input wire scr_pkg::scr_byte_t bitTimeNominal,
  input wire logic recoveryEnable,
  input wire scr_pkg::scr_byte_t recoveredBitTime,
  input wire logic recoveredValid,
  input wire logic [1:0] activeTimeConst
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_clkHigh;
    spiClk [*4];
  endsequence
  sequence s_disabled;
    !recoveryEnable [*3];
  endsequence
  sequence s_canQuiet;
    $stable(canRx) [*4];
  endsequence
  property p_doEnOn;
    !spiCsN |=> spiDoEn;
  endproperty
  property p_doQuiet;
    !spiDoEn |-> !spiDo;
  endproperty
  property p_doSteady;
    s_clkHigh |-> $stable(spiDo);
  endproperty
  property p_validPulse;
    recoveredValid |=> !recoveredValid;
  endproperty
  property p_noValidOff;
    s_disabled |=> !recoveredValid;
  endproperty
  property p_noValidQuiet;
    s_canQuiet |-> !recoveredValid;
  endproperty
  property p_bitHold;
    !recoveredValid && !softResetReq && !$past(softResetReq) |-> $stable(recoveredBitTime);
  endproperty
  property p_restart;
    restartReq |-> ##2 !recoveryEnable;
  endproperty
  property p_softRst;
    softResetReq |-> ##2 !recoveryEnable;
  endproperty
  a_doEnOn: assert property (p_doEnOn)
    else $error("drive enable missing in frame");
  a_doQuiet: assert property (p_doQuiet)
    else $error("data out not low while undriven");
  a_doSteady: assert property (p_doSteady)
    else $error("data out moved while clock high");
  a_validPulse: assert property (p_validPulse)
    else $error("valid longer than one cycle");
  a_noValidOff: assert property (p_noValidOff)
    else $error("valid while recovery disabled");
  a_noValidQuiet: assert property (p_noValidQuiet)
    else $error("valid without receive edge");
  a_bitHold: assert property (p_bitHold)
    else $error("bit time moved without valid");
  a_restart: assert property (p_restart)
    else $error("restart left recovery enabled");
  a_softRst: assert property (p_softRst)
    else $error("soft reset left recovery enabled");
endmodule

bind scr_cdr_regs scr_cdr_regs_monitor #(.QCNT_W(QCNT_W)) u_mon (
  .sys_clk(sys_clk), .arst_n(arst_n), .spiCsN(spiCsN), .spiClk(spiClk), .spiDi(spiDi),
  .spiDo(spiDo), .spiDoEn(spiDoEn), .softResetReq(softResetReq), .restartReq(restartReq),
  .canRx(canRx), .bitTimeNominal(bitTimeNominal), .recoveryEnable(recoveryEnable),
  .recoveredBitTime(recoveredBitTime), .recoveredValid(recoveredValid),
  .activeTimeConst(activeTimeConst)
);

/* File: testbench/scr_spi_master.sv */
`timescale 1ns/1ps
module scr_spi_master (
  input wire logic sys_clk,
  output logic spiCsN,
  output logic spiClk,
  output logic spiDi,
  input wire logic spiDo
);
  initial begin
    spiCsN = 1'b1;
    spiClk = 1'b0;
    spiDi = 1'b0;
  end
  task automatic xfer(input logic [6:0] a, input logic mode, input scr_pkg::scr_byte_t d,
      input int nbits, output scr_pkg::scr_byte_t q);
    logic [15:0] frame;
    frame = {d, mode, a};
    q = 8'h00;
    @(posedge sys_clk);
    spiCsN <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spiDi <= frame[i];
      repeat (5) @(posedge sys_clk);
      if (i >= 8) q[i-8] = spiDo;
      spiClk <= 1'b1;
      repeat (5) @(posedge sys_clk);
      spiClk <= 1'b0;
    end
    repeat (5) @(posedge sys_clk);
    spiCsN <= 1'b1;
    spiDi <= ~spiDi;
    repeat (5) @(posedge sys_clk);
  endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic softResetReq = 1'b0;
  logic restartReq = 1'b0;
  logic canRx = 1'b1;
  scr_pkg::scr_byte_t bitTimeNominal = 8'hA0;
  logic spiCsN, spiClk, spiDi, spiDo, spiDoEn, recoveryEnable, recoveredValid;
  scr_pkg::scr_byte_t recoveredBitTime, rdv;
  logic [1:0] activeTimeConst;
  int n_mismatch = 0;
  int samples_checked = 0;
  int nv;
  always #5 sys_clk = ~sys_clk;
  scr_spi_master mst (.sys_clk(sys_clk), .spiCsN(spiCsN), .spiClk(spiClk), .spiDi(spiDi),
    .spiDo(spiDo));
  scr_cdr_regs #(.QCNT_W(9)) DUT (.sys_clk(sys_clk), .arst_n(arst_n), .spiCsN(spiCsN),
    .spiClk(spiClk), .spiDi(spiDi), .spiDo(spiDo), .spiDoEn(spiDoEn),
    .softResetReq(softResetReq), .restartReq(restartReq), .canRx(canRx),
    .bitTimeNominal(bitTimeNominal), .recoveryEnable(recoveryEnable),
    .recoveredBitTime(recoveredBitTime), .recoveredValid(recoveredValid),
    .activeTimeConst(activeTimeConst));
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk8(input string what, input scr_pkg::scr_byte_t g, input scr_pkg::scr_byte_t e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input scr_pkg::scr_byte_t d);
    mst.xfer(a, 1'b1, d, 16, rdv);
  endtask
  task automatic rdchk(input string what, input logic [6:0] a, input scr_pkg::scr_byte_t e);
    mst.xfer(a, 1'b0, 8'h00, 16, rdv);
    chk8(what, rdv, e);
  endtask
  task automatic run(input scr_pkg::scr_byte_t c1, input int gap);
    wr(7'h3C, c1 & 8'hFE);
    wr(7'h3C, c1);
    nv = 0;
    for (int k = 0; k < 3 * gap + 10; k++) begin
      @(posedge sys_clk);
      if (recoveredValid === 1'b1) nv++;
      canRx <= (k >= 3 * gap) || (k % gap >= gap / 2);
    end
  endtask
  task automatic t_regs();
    rdchk("ctrl1", 7'h3C, 8'h04);
    rdchk("clkctrl", 7'h3D, 8'h00);
    rdchk("upper", 7'h3E, 8'hA8);
    rdchk("lower", 7'h3F, 8'h98);
    rdchk("unmapped", 7'h10, 8'h00);
    wr(7'h3C, 8'hFF);
    rdchk("ctrl1", 7'h3C, 8'h0D);
    chk8("enable", {7'h00, recoveryEnable}, 8'h01);
    wr(7'h3D, 8'hFF);
    rdchk("clkctrl", 7'h3D, 8'h03);
    wr(7'h3D, 8'h00);
    wr(7'h3C, 8'h00);
    chk8("enable", {7'h00, recoveryEnable}, 8'h00);
    mst.xfer(7'h3E, 1'b1, 8'h55, 12, rdv);
    rdchk("upper", 7'h3E, 8'hA8);
    $display("test regs done");
  endtask
  task automatic t_restart();
    wr(7'h3C, 8'h0D);
    wr(7'h3E, 8'h55);
    @(posedge sys_clk);
    restartReq <= 1'b1;
    @(posedge sys_clk);
    restartReq <= 1'b0;
    rdchk("ctrl1", 7'h3C, 8'h0C);
    rdchk("upper", 7'h3E, 8'h55);
    softResetReq <= 1'b1;
    @(posedge sys_clk);
    softResetReq <= 1'b0;
    rdchk("ctrl1", 7'h3C, 8'h04);
    rdchk("upper", 7'h3E, 8'hA8);
    $display("test restart done");
  endtask
  task automatic t_recover();
    run(8'h05, 160);
    chk8("valid count", 8'(nv), 8'h02);
    chk8("bit time", recoveredBitTime, 8'hA0);
    rdchk("status", 7'h4F, 8'h0C);
    wr(7'h3E, 8'h9F);
    wr(7'h3F, 8'h90);
    run(8'h05, 160);
    chk8("bit time", recoveredBitTime, 8'h9F);
    rdchk("status", 7'h4F, 8'h0D);
    rdchk("status", 7'h4F, 8'h0D);
    wr(7'h4F, 8'h00);
    rdchk("status", 7'h4F, 8'h0C);
    wr(7'h3E, 8'hB0);
    wr(7'h3F, 8'hA1);
    run(8'h05, 160);
    chk8("bit time", recoveredBitTime, 8'hA1);
    rdchk("status", 7'h4F, 8'h0E);
    $display("test recover done");
  endtask
  task automatic t_clksel();
    int gaps [4] = '{600, 600, 600, 1200};
    int nexp [4] = '{0, 2, 2, 2};
    bitTimeNominal <= 8'h96;
    wr(7'h3E, 8'hA8);
    wr(7'h3F, 8'h90);
    for (int i = 0; i < 4; i++) begin
      wr(7'h3D, 8'(i));
      run(8'h05, gaps[i]);
      chk8("valid count", 8'(nv), 8'(nexp[i]));
      if (nexp[i] > 0) chk8("bit time", recoveredBitTime, 8'h96);
    end
    wr(7'h3D, 8'h00);
    $display("test clksel done");
  endtask
  task automatic t_filter();
    int bt [9] = '{2, 2, 2, 2, 3, 4, 8, 9, 10};
    int ex [9] = '{0, 1, 2, 2, 2, 1, 1, 0, 0};
    bitTimeNominal <= 8'h10;
    wr(7'h3E, 8'h20);
    wr(7'h3F, 8'h08);
    for (int i = 0; i < 9; i++) begin
      run(8'(((i < 4) ? i : 3) * 4 + 1), bt[i] * 16);
      chk8("time const", {6'h00, activeTimeConst}, 8'(ex[i]));
    end
    $display("test filter done");
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_restart();
    t_recover();
    t_clksel();
    t_filter();
    end_sim();
  end
endmodule
